/* File: include/csf_pkg.sv */
// constants shared by the cipher status flag block
`default_nettype none
package csf_pkg;
	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam logic [7:0]  CSF_CTRL_OFS       = 8'h00;
	localparam logic [7:0]  CSF_STATUS_OFS     = 8'h1c;
	localparam logic [7:0]  CSF_IRQ_STAT_OFS   = 8'h20;
	localparam logic [7:0]  CSF_IRQ_MASK_OFS   = 8'h24;
	localparam int          CSF_ADDR_W         = 8;
	localparam logic [31:0] CSF_STATUS_RST     = 32'h0000_0000;
	// ****************************************
	// field positions
	// ****************************************
	localparam int          CSF_SOFT_RESET_BIT = 0;
	localparam int          CSF_OUT_READY_BIT  = 0;
	localparam int          CSF_SEEN_BIT       = 8;
	localparam int          CSF_TYPE_LSB       = 12;
	localparam int          CSF_TYPE_MSB       = 15;
	localparam int          CSF_TAG_READY_BIT  = 16;
	// interrupt status and mask layout
	localparam int          CSF_IRQ_N          = 3;
	localparam int          CSF_IRQ_OUT_BIT    = 0;
	localparam int          CSF_IRQ_BAD_BIT    = 1;
	localparam int          CSF_IRQ_TAG_BIT    = 2;
	// ****************************************
	// access type codes
	// ****************************************
	localparam int          CSF_HIT_N          = 6;
	localparam logic [3:0]  CSF_TYPE_RST       = 4'h0;
	localparam logic [3:0]  CSF_INPUT_WRITE_WHILE_BUSY  = 4'h0;
	localparam logic [3:0]  CSF_OUTPUT_READ_WHILE_BUSY  = 4'h1;
	localparam logic [3:0]  CSF_CONFIG_WRITE_WHILE_BUSY = 4'h2;
	localparam logic [3:0]  CSF_OUTPUT_READ_IN_SUBKEY   = 4'h3;
	localparam logic [3:0]  CSF_CONFIG_WRITE_IN_SUBKEY  = 4'h4;
	localparam logic [3:0]  CSF_WRITE_ONLY_READ         = 4'h5;
	localparam logic [1:0]  CSF_START_MODE_CHECKED      = 2'h2;
endpackage
`default_nettype wire

/* File: include/csf_reg_if.sv */
// internal register access carrier between bus slave and register file
`timescale 1ns/1ps
`default_nettype none
interface csf_reg_if;
	logic        wr;
	logic        rd;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic        mapped;
	modport bus  (output wr, rd, addr, wdata, input rdata, mapped);
	modport regs (input wr, rd, addr, wdata, output rdata, mapped);
endinterface
`default_nettype wire

/* File: rtl/csf_apb_slave.sv */
// apb slave front end with one wait state and registered answer
`timescale 1ns/1ps
`default_nettype none
module csf_apb_slave
	import csf_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        rstn_i,
	input  wire logic        ce_i,
	// apb
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic             pready_o,
	output logic [31:0]      prdata_o,
	output logic             pslverr_o,
	// register side
	csf_reg_if.bus           rif
);
	wire access_wait = psel_i & penable_i & ~pready_o;
	wire access_done = psel_i & penable_i & pready_o;

	// effects land only on the completing edge
	assign rif.wr    = access_done & pwrite_i & ce_i;
	assign rif.rd    = access_done & ~pwrite_i & ce_i;
	assign rif.addr  = paddr_i;
	assign rif.wdata = pwdata_i;

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pready_o  <= 1'b0;
			prdata_o  <= 32'h0000_0000;
			pslverr_o <= 1'b0;
		end else if (ce_i) begin
			pready_o  <= access_wait;
			prdata_o  <= (access_wait & ~pwrite_i & rif.mapped) ? rif.rdata : 32'h0000_0000;
			pslverr_o <= access_wait & ~rif.mapped;
		end
	end
endmodule
`default_nettype wire

/* File: rtl/csf_irq.sv */
// sticky interrupt status with write-one-to-clear and mask
`timescale 1ns/1ps
`default_nettype none
module csf_irq #(
	parameter int N = 3
) (
	// clock and reset
	input  wire logic         ref_clk_i,
	input  wire logic         rstn_i,
	input  wire logic         ce_i,
	// events and software access
	input  wire logic [N-1:0] event_i,
	input  wire logic         stat_wr_i,
	input  wire logic         mask_wr_i,
	input  wire logic [N-1:0] wdata_i,
	// state
	output logic      [N-1:0] stat_o,
	output logic      [N-1:0] mask_o,
	output logic              irq_o
);
	// set beats a write-one-to-clear in the same cycle
	logic [N-1:0] next_stat;

	genvar g;
	for (g = 0; g < N; g++) begin : g_bit
		assign next_stat[g] = event_i[g] | (stat_o[g] & ~(stat_wr_i & wdata_i[g]));
	end

	// one process owns each vector, so no bit has two writers
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			stat_o <= '0;
			mask_o <= '0;
		end else if (ce_i) begin
			stat_o <= next_stat;
			if (mask_wr_i) begin
				mask_o <= wdata_i;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_o <= 1'b0;
		end else if (ce_i) begin
			irq_o <= |(stat_o & mask_o);
		end
	end
endmodule
`default_nettype wire

/* File: rtl/csf_top.sv */
// cipher status flags and disallowed access detection
//
// Contract
// - the tag-ready flag (status bit 16) rises once tag generation completes; clear means no valid tag.
// - the tag-ready flag falls on a tag register read, a new processing start or a new key write.
// - a 4-bit access-type field (status 15:12) is overwritten by each new disallowed access.
// - codes 0, 1, 2 mark input write in start mode 2, output read, config write during processing.
// - codes 3, 4, 5 mark output read and config write in sub-key generation, and write-only reads.
// - the access-type field clears only on the soft reset command, never on a status read.
// - the access-seen flag (status bit 8) sets on any disallowed access and clears on soft reset.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module csf_top
	import csf_pkg::*;
(
	// clock, reset, enable
	input  wire logic        ref_clk_i,
	input  wire logic        rstn_i,
	input  wire logic        ce_i,
	// apb
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic             pready_o,
	output logic [31:0]      prdata_o,
	output logic             pslverr_o,
	// engine state
	input  wire logic        busy_i,
	input  wire logic        subkey_i,
	input  wire logic [1:0]  start_mode_select_i,
	// engine events, one-cycle pulses
	input  wire logic        tag_done_i,
	input  wire logic        tag_read_i,
	input  wire logic        run_start_i,
	input  wire logic        key_write_i,
	input  wire logic        run_done_i,
	input  wire logic        output_read_i,
	// engine register accesses, one-cycle pulses
	input  wire logic        input_write_i,
	input  wire logic        output_read_acc_i,
	input  wire logic        config_write_i,
	input  wire logic        write_only_read_i,
	// flags and commands
	output logic             tag_ready_flag_o,
	output logic             output_ready_flag_o,
	output logic             bad_access_seen_o,
	output logic [3:0]       bad_access_type_o,
	output logic             soft_reset_cmd_o,
	output logic             irq_o
);
	// ****************************************
	// bus slave
	// ****************************************
	csf_reg_if rif ();

	csf_apb_slave u_apb (
		.ref_clk_i (ref_clk_i),
		.rstn_i    (rstn_i),
		.ce_i      (ce_i),
		.psel_i    (psel_i),
		.penable_i (penable_i),
		.pwrite_i  (pwrite_i),
		.paddr_i   (paddr_i),
		.pwdata_i  (pwdata_i),
		.pready_o  (pready_o),
		.prdata_o  (prdata_o),
		.pslverr_o (pslverr_o),
		.rif       (rif.bus)
	);

	// ****************************************
	// address decode
	// ****************************************
	wire sel_ctrl     = (rif.addr == CSF_CTRL_OFS);
	wire sel_status   = (rif.addr == CSF_STATUS_OFS);
	wire sel_irq_stat = (rif.addr == CSF_IRQ_STAT_OFS);
	wire sel_irq_mask = (rif.addr == CSF_IRQ_MASK_OFS);

	assign rif.mapped = sel_ctrl | sel_status | sel_irq_stat | sel_irq_mask;

	// status is read-only: writes to it are accepted and dropped
	wire soft_rst     = rif.wr & sel_ctrl & rif.wdata[CSF_SOFT_RESET_BIT];
	wire irq_stat_wr  = rif.wr & sel_irq_stat;
	wire irq_mask_wr  = rif.wr & sel_irq_mask;
	wire status_rd    = rif.rd & sel_status;

	// ****************************************
	// disallowed access detection
	// ****************************************
	logic [CSF_HIT_N-1:0] hit;

	assign hit[0] = busy_i & input_write_i
		& (start_mode_select_i == CSF_START_MODE_CHECKED);
	assign hit[1] = busy_i & output_read_acc_i;
	assign hit[2] = busy_i & config_write_i;
	assign hit[3] = subkey_i & output_read_acc_i;
	assign hit[4] = subkey_i & config_write_i;
	assign hit[5] = write_only_read_i;

	wire any_hit = |hit;

	// lowest code wins when two accesses land in one cycle
	logic [3:0] hit_code;
	always_comb begin
		hit_code = CSF_TYPE_RST;
		for (int i = CSF_HIT_N - 1; i >= 0; i--) begin
			if (hit[i]) hit_code = 4'(i);
		end
	end

	// ****************************************
	// next flag values
	// ****************************************
	// a detected event wins over any clear in the same cycle
	wire tag_clear = tag_read_i | run_start_i | key_write_i | soft_rst;

	wire       next_tag_ready    = tag_done_i | (tag_ready_flag_o & ~tag_clear);
	wire       next_output_ready = run_done_i
		| (output_ready_flag_o & ~(output_read_i | run_start_i | soft_rst));
	wire       next_seen         = any_hit | (bad_access_seen_o & ~soft_rst);
	wire [3:0] next_type         = any_hit ? hit_code
		: (soft_rst ? CSF_TYPE_RST : bad_access_type_o);

	// ****************************************
	// flag registers
	// ****************************************
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tag_ready_flag_o    <= 1'b0;
			output_ready_flag_o <= 1'b0;
			bad_access_seen_o   <= 1'b0;
			bad_access_type_o   <= CSF_TYPE_RST;
			soft_reset_cmd_o    <= 1'b0;
		end else if (ce_i) begin
			tag_ready_flag_o    <= next_tag_ready;
			output_ready_flag_o <= next_output_ready;
			bad_access_seen_o   <= next_seen;
			bad_access_type_o   <= next_type;
			soft_reset_cmd_o    <= soft_rst;
		end
	end

	// ****************************************
	// interrupts
	// ****************************************
	logic [CSF_IRQ_N-1:0] irq_event;
	logic [CSF_IRQ_N-1:0] irq_stat;
	logic [CSF_IRQ_N-1:0] irq_mask;

	assign irq_event[CSF_IRQ_OUT_BIT] = run_done_i;
	assign irq_event[CSF_IRQ_BAD_BIT] = any_hit;
	assign irq_event[CSF_IRQ_TAG_BIT] = tag_done_i;

	csf_irq #(
		.N (CSF_IRQ_N)
	) u_irq (
		.ref_clk_i (ref_clk_i),
		.rstn_i    (rstn_i),
		.ce_i      (ce_i),
		.event_i   (irq_event),
		.stat_wr_i (irq_stat_wr),
		.mask_wr_i (irq_mask_wr),
		.wdata_i   (rif.wdata[CSF_IRQ_N-1:0]),
		.stat_o    (irq_stat),
		.mask_o    (irq_mask),
		.irq_o     (irq_o)
	);

	// ****************************************
	// read mux
	// ****************************************
	logic [31:0] status_word;
	always_comb begin
		status_word = CSF_STATUS_RST;
		status_word[CSF_TAG_READY_BIT]            = tag_ready_flag_o;
		status_word[CSF_TYPE_MSB:CSF_TYPE_LSB]    = bad_access_type_o;
		status_word[CSF_SEEN_BIT]                 = bad_access_seen_o;
		status_word[CSF_OUT_READY_BIT]            = output_ready_flag_o;
	end

	// control is write-only and reads as zero
	assign rif.rdata = sel_status   ? status_word
		: sel_irq_stat ? {{(32-CSF_IRQ_N){1'b0}}, irq_stat}
		: sel_irq_mask ? {{(32-CSF_IRQ_N){1'b0}}, irq_mask}
		: 32'h0000_0000;

	// ****************************************
	// checks
	// ****************************************
	sequence s_soft_reset;
		ce_i && soft_rst && !any_hit;
	endsequence

	sequence s_tag_clear;
		ce_i && !tag_done_i && (tag_read_i || run_start_i || key_write_i);
	endsequence

	sequence s_status_read_quiet;
		ce_i && status_rd && !soft_rst && !any_hit;
	endsequence

	a_tag_ready_set: assert property (
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(ce_i && tag_done_i) |=> tag_ready_flag_o ##0 status_word[CSF_TAG_READY_BIT])
		else $error("tag ready flag did not rise after tag completion");

	a_tag_ready_clear: assert property (
		@(posedge ref_clk_i) disable iff (!rstn_i)
		s_tag_clear |=> !tag_ready_flag_o)
		else $error("tag ready flag did not clear");

	a_type_last_hit: assert property (
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(ce_i && any_hit) |=> bad_access_type_o == $past(hit_code)
			&& status_word[CSF_TYPE_MSB:CSF_TYPE_LSB] == bad_access_type_o)
		else $error("access type field not overwritten by newest access");

	a_busy_codes: assert property (
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(ce_i && busy_i && !subkey_i && output_read_acc_i && !write_only_read_i
			&& !input_write_i)
		|=> bad_access_type_o == CSF_OUTPUT_READ_WHILE_BUSY)
		else $error("output read while busy not coded as 1");

	a_input_code: assert property (
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(ce_i && busy_i && input_write_i
			&& start_mode_select_i == CSF_START_MODE_CHECKED)
		|=> bad_access_type_o == CSF_INPUT_WRITE_WHILE_BUSY && bad_access_seen_o)
		else $error("input write in start mode 2 not coded as 0");

	a_subkey_codes: assert property (
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(ce_i && subkey_i && !busy_i && config_write_i && !output_read_acc_i)
		|=> bad_access_type_o == CSF_CONFIG_WRITE_IN_SUBKEY)
		else $error("config write in sub-key generation not coded as 4");

	a_wo_read_code: assert property (
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(ce_i && write_only_read_i && hit[CSF_HIT_N-2:0] == '0)
		|=> bad_access_type_o == CSF_WRITE_ONLY_READ)
		else $error("write-only read not coded as 5");

	a_type_soft_clear: assert property (
		@(posedge ref_clk_i) disable iff (!rstn_i)
		s_soft_reset |=> bad_access_type_o == CSF_TYPE_RST && !bad_access_seen_o
			&& soft_reset_cmd_o)
		else $error("soft reset did not clear access state");

	a_status_read_keeps: assert property (
		@(posedge ref_clk_i) disable iff (!rstn_i)
		s_status_read_quiet |=> $stable(bad_access_type_o) && $stable(bad_access_seen_o))
		else $error("status read disturbed access state");

	a_seen_sticky: assert property (
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(ce_i && any_hit) ##1 (!(ce_i && soft_rst))[*2] |=> bad_access_seen_o)
		else $error("access seen flag lost without soft reset");

	a_out_ready_set: assert property (
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(ce_i && run_done_i) |=> output_ready_flag_o ##0 status_word[CSF_OUT_READY_BIT])
		else $error("output ready flag did not rise after run end");

	a_irq_follows: assert property (
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(ce_i && |(irq_stat & irq_mask)) |=> irq_o)
		else $error("interrupt output missed an unmasked event");

	// ****************************************
	// bus, hold and freeze checks
	// ****************************************
	sequence s_access_wait;
		ce_i && psel_i && penable_i && !pready_o;
	endsequence

	sequence s_idle_flags;
		ce_i && !any_hit && !soft_rst;
	endsequence

	sequence s_out_clear;
		ce_i && !run_done_i && (output_read_i || run_start_i || soft_rst);
	endsequence

	a_ready_wait_state: assert property (
		@(posedge ref_clk_i) disable iff (!rstn_i)
		s_access_wait |=> pready_o)
		else $error("no answer one cycle after the access phase");

	a_ready_one_cycle: assert property (
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(ce_i && pready_o) |=> !pready_o)
		else $error("ready stood for more than one cycle");

	a_unmapped_error: assert property (
		@(posedge ref_clk_i) disable iff (!rstn_i)
		s_access_wait ##0 !rif.mapped |=> pslverr_o && prdata_o == 32'h0000_0000)
		else $error("unmapped access not answered with an error");

	a_mapped_no_error: assert property (
		@(posedge ref_clk_i) disable iff (!rstn_i)
		s_access_wait ##0 rif.mapped |=> !pslverr_o)
		else $error("mapped access answered with an error");

	a_status_read_data: assert property (
		@(posedge ref_clk_i) disable iff (!rstn_i)
		s_access_wait ##0 (!pwrite_i && sel_status) |=> prdata_o == $past(status_word))
		else $error("status read returned a stale word");

	a_seen_set: assert property (
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(ce_i && any_hit) |=> bad_access_seen_o && status_word[CSF_SEEN_BIT])
		else $error("access seen flag did not rise");

	a_seen_hold: assert property (
		@(posedge ref_clk_i) disable iff (!rstn_i)
		s_idle_flags |=> $stable(bad_access_seen_o))
		else $error("access seen flag moved without cause");

	a_type_hold: assert property (
		@(posedge ref_clk_i) disable iff (!rstn_i)
		s_idle_flags |=> $stable(bad_access_type_o))
		else $error("access type field moved without cause");

	a_out_ready_clear: assert property (
		@(posedge ref_clk_i) disable iff (!rstn_i)
		s_out_clear |=> !output_ready_flag_o)
		else $error("output ready flag did not clear");

	a_soft_flags_clear: assert property (
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(ce_i && soft_rst && !tag_done_i && !run_done_i)
		|=> !tag_ready_flag_o && !output_ready_flag_o)
		else $error("soft reset left a ready flag set");

	a_cmd_one_cycle: assert property (
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(ce_i && soft_reset_cmd_o && !soft_rst) |=> !soft_reset_cmd_o)
		else $error("soft reset command stood for more than one cycle");

	a_freeze_flags: assert property (
		@(posedge ref_clk_i) disable iff (!rstn_i)
		!ce_i |=> $stable(tag_ready_flag_o) && $stable(output_ready_flag_o)
			&& $stable(bad_access_seen_o) && $stable(bad_access_type_o) && $stable(irq_o))
		else $error("state moved while the clock enable was low");

	a_irq_quiet: assert property (
		@(posedge ref_clk_i) disable iff (!rstn_i)
		(ce_i && (irq_stat & irq_mask) == '0) |=> !irq_o)
		else $error("interrupt output high with nothing unmasked pending");
endmodule
`default_nettype wire

/* File: verification/csf_top_tb.sv */
// self-checking testbench for the cipher status flag block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin err_total++; \
	$display("[ERR] %0t got %h expected %h", $time, got, exp); end end
module csf_top_tb
	import csf_pkg::*;
;
	// ****************************************
	// stimulus and observed signals
	// ****************************************
	logic        ref_clk_i = 1'b0;
	logic        rstn_i    = 1'b0;
	logic        ce_i      = 1'b1;
	logic        psel_i    = 1'b0;
	logic        penable_i = 1'b0;
	logic        pwrite_i  = 1'b0;
	logic [7:0]  paddr_i   = 8'h00;
	logic [31:0] pwdata_i  = 32'h0;
	logic        busy_i    = 1'b0;
	logic        subkey_i  = 1'b0;
	logic [1:0]  mode      = 2'h0;
	logic [9:0]  pl        = 10'h0;
	logic        pready_o, pslverr_o, tag_o, out_o, seen_o, swr_o, irq_o;
	logic [31:0] prdata_o;
	logic [3:0]  type_o;
	logic [31:0] rd;
	logic        er;
	int          err_total = 0;
	int          compares  = 0;
	int          seed      = 94293;
	int          last;
	always #10 ref_clk_i = ~ref_clk_i;

	csf_top csf_top_i (
		.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ce_i(ce_i),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
		.paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
		.prdata_o(prdata_o), .pslverr_o(pslverr_o),
		.busy_i(busy_i), .subkey_i(subkey_i), .start_mode_select_i(mode),
		.tag_done_i(pl[0]), .tag_read_i(pl[1]), .run_start_i(pl[2]),
		.key_write_i(pl[3]), .run_done_i(pl[4]), .output_read_i(pl[5]),
		.input_write_i(pl[6]), .output_read_acc_i(pl[7]),
		.config_write_i(pl[8]), .write_only_read_i(pl[9]),
		.tag_ready_flag_o(tag_o), .output_ready_flag_o(out_o),
		.bad_access_seen_o(seen_o), .bad_access_type_o(type_o),
		.soft_reset_cmd_o(swr_o), .irq_o(irq_o)
	);

	// ****************************************
	// expectations and drivers
	// ****************************************
	function automatic logic [31:0] st(logic t, logic [3:0] ty, logic s, logic o);
		return {15'h0, t, ty, 3'h0, s, 7'h0, o};
	endfunction
	// code to the engine access pulse that raises it
	function automatic int acc_bit(int c);
		return (c == 0) ? 6 : (c == 5) ? 9 : (c == 1 || c == 3) ? 7 : 8;
	endfunction
	task automatic wrap_up();
		$display("compares %0d errors %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// read data and response taken at the completing edge only
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge ref_clk_i);
		psel_i    <= 1'b1;
		pwrite_i  <= w;
		paddr_i   <= a;
		pwdata_i  <= d;
		@(posedge ref_clk_i);
		penable_i <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge ref_clk_i);
			if (pready_o === 1'b1) break;
		end
		if (i == 20) begin
			err_total++;
			wrap_up();
		end
		rd        = prdata_o;
		er        = pslverr_o;
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic pulse(input int b);
		@(posedge ref_clk_i);
		pl <= 10'h1 << b;
		@(posedge ref_clk_i);
		pl <= 10'h0;
		#1;
	endtask
	task automatic hit(input int c);
		@(posedge ref_clk_i);
		busy_i   <= (c < 3);
		subkey_i <= (c == 3 || c == 4);
		mode     <= 2'h2;
		pulse(acc_bit(c));
	endtask
	task automatic done_t(input int n);
		$display("test %0d finished, errors so far %0d", n, err_total);
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (5) @(posedge ref_clk_i);
		rstn_i <= 1'b1;
		// reset values, unmapped address
		apb(1'b0, CSF_STATUS_OFS, 32'h0);
		`CHK(rd, CSF_STATUS_RST)
		apb(1'b0, 8'h40, 32'h0);
		`CHK({er, rd}, {1'b1, 32'h0})
		done_t(1);
		// tag ready set and three of its four clears (soft reset not driven here)
		for (int k = 0; k < 3; k++) begin
			pulse(0);
			`CHK(tag_o, 1'b1)
			apb(1'b0, CSF_STATUS_OFS, 32'h0);
			`CHK(rd, st(1'b1, 4'h0, 1'b0, 1'b0))
			pulse(1 + k);
			`CHK(tag_o, 1'b0)
		end
		done_t(2);
		// every access code, status read leaves it in place
		for (int c = 0; c < CSF_HIT_N; c++) begin
			hit(c);
			`CHK({seen_o, type_o}, {1'b1, 4'(c)})
			repeat (2) begin
				apb(1'b0, CSF_STATUS_OFS, 32'h0);
				`CHK(rd, st(1'b0, 4'(c), 1'b1, 1'b0))
			end
		end
		done_t(3);
		// random sequence of hits, only the last one kept
		repeat (8) begin
			last = $unsigned($random(seed)) % CSF_HIT_N;
			hit(last);
		end
		`CHK(type_o, 4'(last))
		done_t(4);
		// soft reset command clears the access state
		apb(1'b1, CSF_CTRL_OFS, 32'h1);
		#1;
		`CHK(swr_o, 1'b1)
		@(posedge ref_clk_i);
		#1;
		`CHK({seen_o, type_o}, {1'b0, CSF_TYPE_RST})
		// input write outside start mode 2 is allowed
		@(posedge ref_clk_i);
		busy_i <= 1'b1;
		mode   <= 2'h0;
		pulse(6);
		`CHK(seen_o, 1'b0)
		done_t(5);
		// output ready set and cleared
		pulse(4);
		`CHK(out_o, 1'b1)
		pulse(5);
		`CHK(out_o, 1'b0)
		pulse(4);
		pulse(2);
		`CHK(out_o, 1'b0)
		done_t(6);
		// interrupt raise, mask, clear
		apb(1'b1, CSF_IRQ_STAT_OFS, 32'h7);
		apb(1'b1, CSF_IRQ_MASK_OFS, 32'h0);
		hit(5);
		repeat (2) @(posedge ref_clk_i);
		#1;
		`CHK(irq_o, 1'b0)
		apb(1'b0, CSF_IRQ_STAT_OFS, 32'h0);
		`CHK(rd[CSF_IRQ_BAD_BIT], 1'b1)
		apb(1'b1, CSF_IRQ_MASK_OFS, 32'h2);
		repeat (2) @(posedge ref_clk_i);
		#1;
		`CHK(irq_o, 1'b1)
		apb(1'b1, CSF_IRQ_STAT_OFS, 32'h2);
		repeat (2) @(posedge ref_clk_i);
		#1;
		`CHK(irq_o, 1'b0)
		done_t(7);
		// clock enable low swallows an event
		@(posedge ref_clk_i);
		ce_i <= 1'b0;
		pulse(0);
		@(posedge ref_clk_i);
		ce_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		#1;
		`CHK(tag_o, 1'b0)
		done_t(8);
		wrap_up();
	end
endmodule
`default_nettype wire
